// [bench/fsp_props.sv]
/* checker for the core-to-controller link of the row programming pair
   assumes one clock, sync high reset, instanced beside the interface */
`timescale 1ns/1ps
module fsp_props #(
    parameter int OP_CYCLES = fsp_pkg::OP_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic warm_rst_i,
    input wire logic sfr_wr,
    input wire logic [15:0] sfr_addr,
    input wire logic [15:0] sfr_wdata,
    input wire logic tbl_wr,
    input wire logic tbl_hi,
    input wire logic [23:0] tbl_ea,
    input wire logic stall
);
    logic [31:0] run_r;
    logic [31:0] run_nxt;
    logic key_hi;
    logic go;
    ////////////////////////////////////////////////////////////////////////////
    // taken second key and taken start writes
    assign key_hi = sfr_wr && !stall && sfr_addr == fsp_pkg::ADDR_KEY
        && sfr_wdata[7:0] == fsp_pkg::KEY_SECOND;
    assign go = sfr_wr && !stall && sfr_addr == fsp_pkg::ADDR_CTRL && sfr_wdata[15];
    // stall run length; warm reset clears it since an abort cuts the run short
    always_comb
    begin
        run_nxt = (stall && !warm_rst_i) ? run_r + 32'h1 : 32'h0;
    end
    always_ff @(posedge ref_clk_i)
    begin
        run_r <= rst_i ? 32'h0 : run_nxt;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    tbl_busy_a: assert property (tbl_wr && !stall |=> stall ##1 !stall)
        else $error("table write busy not one cycle");
    tbl_pair_a: assert property (tbl_wr && tbl_hi && !stall |->
        $past(tbl_wr && !tbl_hi, 2) && $past(tbl_ea, 2) == tbl_ea)
        else $error("high byte write without its low word");
    key_order_a: assert property (key_hi |-> $past(sfr_wr &&
        sfr_addr == fsp_pkg::ADDR_KEY && sfr_wdata[7:0] == fsp_pkg::KEY_FIRST))
        else $error("second key not right after first");
    start_unlock_a: assert property (go |-> $past(key_hi))
        else $error("start not right after second key");
    setup_value_a: assert property (sfr_wr && !stall && !sfr_wdata[15] &&
        sfr_addr == fsp_pkg::ADDR_CTRL |-> sfr_wdata == fsp_pkg::CTL_ERASE_SETUP
        || sfr_wdata == fsp_pkg::CTL_PROG_SETUP)
        else $error("control setup value wrong");
    start_stall_a: assert property (go |=> stall)
        else $error("start did not stall core");
    host_idle_a: assert property (go |=> !(sfr_wr || tbl_wr) [*2])
        else $error("host busy right after start");
    op_length_a: assert property ($fell(stall) && !$past(warm_rst_i) |->
        run_r == 32'h1 || run_r == 32'(OP_CYCLES))
        else $error("stall length wrong");
    cover property (go);
    cover property (tbl_wr && tbl_hi && !stall);
    cover property ($fell(stall) && run_r == 32'(OP_CYCLES));
endmodule

// [bench/tb_fsp.sv]
/* testbench: host sequencer driving the controller through the interface
   assumes the design files and fsp_props are compiled first */
`timescale 1ns/1ps
module tb_fsp;
    localparam int OPC = 20;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic warm_rst_i = 1'b0;
    logic [4:0] latch_idx_i = 5'h00;
    logic cmd_valid_i = 1'b0;
    logic [1:0] cmd_kind_i = 2'h0;
    logic [23:0] cmd_addr_i = 24'h000000;
    logic [23:0] cmd_word_i = 24'h000000;
    logic cmd_ready_o, done_o, fault_o, flash_erase_o, flash_prog_o, op_done_o;
    logic [23:0] latch_data_o;
    logic [23:0] flash_row_o;
    int errors = 0;
    int comparisons = 0;
    int ers = 0;
    int prg = 0;
    int pulses = 0;
    fsp_if bus ();
    fsp_dev #(.OP_CYCLES(OPC)) i_fsp_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .warm_rst_i(warm_rst_i), .bus(bus), .latch_idx_i(latch_idx_i),
        .latch_data_o(latch_data_o), .flash_erase_o(flash_erase_o),
        .flash_prog_o(flash_prog_o), .flash_row_o(flash_row_o), .op_done_o(op_done_o));
    fsp_host i_fsp_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_kind_i(cmd_kind_i), .cmd_addr_i(cmd_addr_i), .cmd_word_i(cmd_word_i),
        .cmd_ready_o(cmd_ready_o), .done_o(done_o), .fault_o(fault_o), .bus(bus));
    fsp_props #(.OP_CYCLES(OPC)) i_fsp_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .warm_rst_i(warm_rst_i), .sfr_wr(bus.sfr_wr), .sfr_addr(bus.sfr_addr),
        .sfr_wdata(bus.sfr_wdata), .tbl_wr(bus.tbl_wr), .tbl_hi(bus.tbl_hi),
        .tbl_ea(bus.tbl_ea), .stall(bus.stall));
    ////////////////////////////////////////////////////////////////////////////
    // clock, and op activity counted at the ports; counts restart on each accept
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i)
    begin
        ers <= cmd_valid_i ? 0 : ers + int'(flash_erase_o === 1'b1);
        prg <= cmd_valid_i ? 0 : prg + int'(flash_prog_o === 1'b1);
        pulses <= cmd_valid_i ? 0 : pulses + int'(op_done_o === 1'b1);
    end
    // load data pattern for one word index
    function automatic logic [23:0] word_of(input int i);
        return {8'h5A ^ 8'(i), 16'hC300 + 16'(i)};
    endfunction
    task automatic check_v(input logic [23:0] got, input logic [23:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one host command, ready and done waits bounded
    task automatic run_cmd(input logic [1:0] kind, input logic [23:0] addr, input int w);
        int n;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 400)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        cmd_word_i = word_of(w);
        {cmd_valid_i, cmd_kind_i, cmd_addr_i} = {1'b1, kind, addr};
        @(posedge ref_clk_i);
        #1;
        cmd_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 400)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        if (n >= 400)
        begin
            errors++;
            $display("mismatch at %0t: command timed out", $time);
            complete_run();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        check_v({21'h0, flash_erase_o, flash_prog_o, fault_o}, 24'h0, "reset");
        $display("test reset done");
        for (int i = 0; i < 32; i++)
        begin
            run_cmd(fsp_pkg::FSP_CMD_LOAD, 24'h006000 + 24'(2 * i), i);
            check_v(24'(ers + prg + pulses), 24'h0, "load moved flash");
        end
        check_v(flash_row_o, 24'h006000, "row from table ea");
        run_cmd(fsp_pkg::FSP_CMD_PROG, 24'h006000, 0);
        check_v(24'(prg), 24'(OPC), "program length");
        check_v({8'(ers), 8'(pulses), 7'h0, fault_o}, 24'h000100, "program end");
        for (int i = 0; i < 32; i++)
        begin
            latch_idx_i = 5'(i);
            @(posedge ref_clk_i);
            #1;
            check_v(latch_data_o, word_of(i), "latch word");
        end
        $display("test load and program done");
        run_cmd(fsp_pkg::FSP_CMD_ERASE, 24'h012340, 0);
        check_v({16'(ers), 7'h0, fault_o}, {16'(OPC), 8'h00}, "erase");
        check_v(flash_row_o, 24'h012340, "erase row");
        $display("test erase done");
        fork
            run_cmd(fsp_pkg::FSP_CMD_ERASE, 24'h00A080, 0);
            begin
                repeat (15) @(posedge ref_clk_i);
                #1;
                warm_rst_i = 1'b1;
                @(posedge ref_clk_i);
                #1;
                warm_rst_i = 1'b0;
            end
        join
        check_v({flash_row_o[22:0], fault_o}, {23'h00A080, 1'b1}, "abort fault");
        run_cmd(fsp_pkg::FSP_CMD_PROG, 24'h00A080, 0);
        check_v({23'(prg), fault_o}, {23'(OPC), 1'b0}, "recovery program");
        $display("test warm abort done");
        complete_run();
    end
endmodule

// [hw/fsp_dev.sv]
/*
 * Row self-programming controller: write latches, address capture,
 * unlock sequence, timed erase/program with core stall.
 * Assumes requests are only presented by the core and are ignored while
 * stall is high; warm_rst_i flags an external or watchdog reset.
 */
`timescale 1ns/1ps
module fsp_dev #(
    parameter int NUM_PANELS = 2,
    parameter int OP_CYCLES = fsp_pkg::OP_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic warm_rst_i,
    fsp_if.dev bus,
    input wire logic [4:0] latch_idx_i,
    output logic [23:0] latch_data_o,
    output logic flash_erase_o,
    output logic flash_prog_o,
    output logic [23:0] flash_row_o,
    output logic op_done_o
);
    localparam int PW = (NUM_PANELS > 1) ? $clog2(NUM_PANELS) : 1;
    localparam int LAT_N = NUM_PANELS * fsp_pkg::ROW_WORDS;

    ////////////////////////////////////////////////////////////////////////////
    // state
    fsp_pkg::fsp_key_e key_r, key_nxt;
    fsp_pkg::fsp_op_e op_r, op_nxt;
    logic start_r, start_nxt;
    logic wallow_r, wallow_nxt;
    logic fault_r, fault_nxt;
    logic twri_r, twri_nxt;
    logic [6:0] opsel_r, opsel_nxt;
    logic [15:0] adr_lo_r, adr_lo_nxt;
    logic [7:0] adr_hi_r, adr_hi_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic tw_stall_r, tw_stall_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic done_r, done_nxt;
    logic [23:0] lat_dout_r;
    logic [23:0] latch_mem [LAT_N];
    logic lat_lo_we;
    logic lat_hi_we;
    logic [PW+4:0] lat_widx;
    logic accept;

    // latch slot of a table address: panel bits above, word index below
    function automatic logic [PW+4:0] slot_of(input logic [23:0] ea);
        logic [PW-1:0] pan;
        pan = ea[fsp_pkg::EA_PANEL_LSB +: PW];
        return {pan, ea[fsp_pkg::EA_IDX_LSB +: fsp_pkg::IDX_W]};
    endfunction

    function automatic logic [15:0] ctl_word(input logic st, input logic wa,
                                             input logic ft, input logic tw,
                                             input logic [6:0] op);
        logic [15:0] w;
        w = 16'h0000;
        w[fsp_pkg::CTL_START_BIT] = st;
        w[fsp_pkg::CTL_WALLOW_BIT] = wa;
        w[fsp_pkg::CTL_FAULT_BIT] = ft;
        w[fsp_pkg::CTL_TWRI_BIT] = tw;
        w[fsp_pkg::OPSEL_W-1:0] = op;
        return w;
    endfunction

    // core requests are only honoured outside a stall
    assign bus.stall = (op_r == fsp_pkg::FSP_OP_RUN) || tw_stall_r;
    assign accept = !bus.stall;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic for registers, unlock and operation timer
    always_comb
    begin
        key_nxt = key_r;
        op_nxt = op_r;
        start_nxt = start_r;
        wallow_nxt = wallow_r;
        fault_nxt = fault_r;
        twri_nxt = twri_r;
        opsel_nxt = opsel_r;
        adr_lo_nxt = adr_lo_r;
        adr_hi_nxt = adr_hi_r;
        cnt_nxt = cnt_r;
        tw_stall_nxt = 1'b0;
        rdata_nxt = rdata_r;
        done_nxt = 1'b0;
        lat_lo_we = 1'b0;
        lat_hi_we = 1'b0;
        lat_widx = slot_of(bus.tbl_ea);

        // timed operation; start bit drops here at the end, or on a warm reset
        if (op_r == fsp_pkg::FSP_OP_RUN)
        begin
            if (cnt_r == 32'(OP_CYCLES - 1))
            begin
                op_nxt = fsp_pkg::FSP_OP_IDLE;
                start_nxt = 1'b0;
                done_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + 32'h0000_0001;
            end
        end

        // register reads; key reads as zero
        if (accept && bus.sfr_rd)
        begin
            case (bus.sfr_addr)
                fsp_pkg::ADDR_CTRL: rdata_nxt = ctl_word(start_r, wallow_r, fault_r,
                                                         twri_r, opsel_r);
                fsp_pkg::ADDR_ADR_LO: rdata_nxt = adr_lo_r;
                fsp_pkg::ADDR_ADR_HI: rdata_nxt = {8'h00, adr_hi_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end

        if (accept && bus.tbl_wr)
        begin
            // latch fill and address capture, unlock key cleared; flash untouched until a start
            lat_lo_we = !bus.tbl_hi;
            lat_hi_we = bus.tbl_hi;
            tw_stall_nxt = 1'b1;
            adr_lo_nxt = bus.tbl_ea[15:0];
            adr_hi_nxt = bus.tbl_ea[23:16];
            key_nxt = fsp_pkg::FSP_KEY_IDLE;
        end
        else if (accept && bus.sfr_wr)
        begin
            key_nxt = fsp_pkg::FSP_KEY_IDLE;
            case (bus.sfr_addr)
                fsp_pkg::ADDR_CTRL:
                begin
                    wallow_nxt = bus.sfr_wdata[fsp_pkg::CTL_WALLOW_BIT];
                    twri_nxt = bus.sfr_wdata[fsp_pkg::CTL_TWRI_BIT];
                    opsel_nxt = bus.sfr_wdata[fsp_pkg::OPSEL_W-1:0];
                    fault_nxt = bus.sfr_wdata[fsp_pkg::CTL_FAULT_BIT];
                    // start needs an open unlock, write allow and a row op
                    if (bus.sfr_wdata[fsp_pkg::CTL_START_BIT] &&
                        key_r == fsp_pkg::FSP_KEY_OPEN &&
                        bus.sfr_wdata[fsp_pkg::CTL_WALLOW_BIT] &&
                        (bus.sfr_wdata[6:0] == fsp_pkg::OP_ROW_ERASE ||
                         bus.sfr_wdata[6:0] == fsp_pkg::OP_ROW_PROG))
                    begin
                        start_nxt = 1'b1;
                        op_nxt = fsp_pkg::FSP_OP_RUN;
                        cnt_nxt = 32'h0000_0000;
                    end
                end
                fsp_pkg::ADDR_ADR_LO: adr_lo_nxt = bus.sfr_wdata;
                fsp_pkg::ADDR_ADR_HI: adr_hi_nxt = bus.sfr_wdata[7:0];
                fsp_pkg::ADDR_KEY:
                begin
                    if (key_r == fsp_pkg::FSP_KEY_IDLE &&
                        bus.sfr_wdata[7:0] == fsp_pkg::KEY_FIRST)
                        key_nxt = fsp_pkg::FSP_KEY_GOT1;
                    else if (key_r == fsp_pkg::FSP_KEY_GOT1 &&
                             bus.sfr_wdata[7:0] == fsp_pkg::KEY_SECOND)
                        key_nxt = fsp_pkg::FSP_KEY_OPEN;
                    else
                        key_nxt = fsp_pkg::FSP_KEY_IDLE;
                end
                default: key_nxt = fsp_pkg::FSP_KEY_IDLE;
            endcase
        end
        // writes during a stall never reach here, so a running start holds

        // warm reset aborts; fault set wins over a same-cycle clear
        if (warm_rst_i)
        begin
            if (op_r == fsp_pkg::FSP_OP_RUN)
                fault_nxt = 1'b1;
            op_nxt = fsp_pkg::FSP_OP_IDLE;
            start_nxt = 1'b0;
            wallow_nxt = 1'b0;
            twri_nxt = 1'b0;
            opsel_nxt = 7'h00;
            key_nxt = fsp_pkg::FSP_KEY_IDLE;
            tw_stall_nxt = 1'b0;
            done_nxt = 1'b0;
            lat_lo_we = 1'b0;
            lat_hi_we = 1'b0;
            adr_lo_nxt = adr_lo_r;
            adr_hi_nxt = adr_hi_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers; write allow clear out of reset
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            key_r <= fsp_pkg::FSP_KEY_IDLE;
            op_r <= fsp_pkg::FSP_OP_IDLE;
            start_r <= 1'b0;
            wallow_r <= 1'b0;
            fault_r <= 1'b0;
            twri_r <= 1'b0;
            opsel_r <= 7'h00;
            adr_lo_r <= fsp_pkg::ADR_RESET;
            adr_hi_r <= 8'h00;
            cnt_r <= 32'h0000_0000;
            tw_stall_r <= 1'b0;
            rdata_r <= 16'h0000;
            done_r <= 1'b0;
        end
        else
        begin
            key_r <= key_nxt;
            op_r <= op_nxt;
            start_r <= start_nxt;
            wallow_r <= wallow_nxt;
            fault_r <= fault_nxt;
            twri_r <= twri_nxt;
            opsel_r <= opsel_nxt;
            adr_lo_r <= adr_lo_nxt;
            adr_hi_r <= adr_hi_nxt;
            cnt_r <= cnt_nxt;
            tw_stall_r <= tw_stall_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write latches, one 32-word set per panel; no reset, contents are data
    always_ff @(posedge ref_clk_i)
    begin
        if (lat_lo_we)
            latch_mem[lat_widx][15:0] <= bus.tbl_wdata;
        if (lat_hi_we)
            latch_mem[lat_widx][23:16] <= bus.tbl_wdata[7:0];
        // panel bit sits in the low address word, same as on the write side
        lat_dout_r <= latch_mem[{adr_lo_r[fsp_pkg::EA_PANEL_LSB +: PW], latch_idx_i}];
    end

    // flash array side: row base with word index bits zeroed
    assign flash_row_o = {adr_hi_r, adr_lo_r[15:fsp_pkg::EA_ROW_LSB], 6'h00};
    assign flash_erase_o = (op_r == fsp_pkg::FSP_OP_RUN) &&
                           (opsel_r == fsp_pkg::OP_ROW_ERASE);
    assign flash_prog_o = (op_r == fsp_pkg::FSP_OP_RUN) &&
                          (opsel_r == fsp_pkg::OP_ROW_PROG);
    assign latch_data_o = lat_dout_r;
    assign op_done_o = done_r;
    assign bus.sfr_rdata = rdata_r;
endmodule

// [hw/fsp_host.sv]
/*
 * Core-side sequencer: turns load, erase and program commands into the
 * register and table write sequences the controller expects.
 * Assumes the controller holds requests off with stall.
 */
`timescale 1ns/1ps
module fsp_host (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_kind_i,
    input wire logic [23:0] cmd_addr_i,
    input wire logic [23:0] cmd_word_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic fault_o,
    fsp_if.core bus
);
    fsp_pkg::fsp_hst_e st_r, st_nxt;
    logic [1:0] kind_r, kind_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic [23:0] word_r, word_nxt;
    logic [2:0] step_r, step_nxt;
    logic [1:0] nop_r, nop_nxt;
    logic done_r, done_nxt;
    logic fault_r, fault_nxt;
    fsp_pkg::fsp_req_s req;

    // step table for each command
    function automatic fsp_pkg::fsp_req_s step_req(input logic [1:0] k, input logic [2:0] s,
                                                   input logic [23:0] a, input logic [23:0] w);
        fsp_pkg::fsp_req_s r;
        r = '0;
        case (k)
            fsp_pkg::FSP_CMD_LOAD:
            begin
                r.tbl = 1'b1;
                r.hi = s[0];
                // upper byte of a high write is filler the controller must drop
                r.data = s[0] ? {w[7:0], w[23:16]} : w[15:0];
                r.last = s[0];
            end
            fsp_pkg::FSP_CMD_ERASE:
            begin
                case (s)
                    3'h0: {r.addr, r.data} = {fsp_pkg::ADDR_CTRL, fsp_pkg::CTL_ERASE_SETUP};
                    3'h1: {r.addr, r.data} = {fsp_pkg::ADDR_ADR_HI, 8'h00, a[23:16]};
                    3'h2: {r.addr, r.data} = {fsp_pkg::ADDR_ADR_LO, a[15:6], 6'h00};
                    3'h3: {r.addr, r.data} = {fsp_pkg::ADDR_KEY, 8'h00, fsp_pkg::KEY_FIRST};
                    3'h4: {r.addr, r.data} = {fsp_pkg::ADDR_KEY, 8'h00, fsp_pkg::KEY_SECOND};
                    default:
                    begin
                        r.addr = fsp_pkg::ADDR_CTRL;
                        r.data = fsp_pkg::CTL_ERASE_SETUP | fsp_pkg::CTL_START_MASK;
                        r.last = 1'b1;
                        r.start = 1'b1;
                    end
                endcase
            end
            default:
            begin
                case (s)
                    3'h0: {r.addr, r.data} = {fsp_pkg::ADDR_CTRL, fsp_pkg::CTL_PROG_SETUP};
                    3'h1: {r.addr, r.data} = {fsp_pkg::ADDR_KEY, 8'h00, fsp_pkg::KEY_FIRST};
                    3'h2: {r.addr, r.data} = {fsp_pkg::ADDR_KEY, 8'h00, fsp_pkg::KEY_SECOND};
                    default:
                    begin
                        r.addr = fsp_pkg::ADDR_CTRL;
                        r.data = fsp_pkg::CTL_PROG_SETUP | fsp_pkg::CTL_START_MASK;
                        r.last = 1'b1;
                        r.start = 1'b1;
                    end
                endcase
            end
        endcase
        return r;
    endfunction

    assign req = step_req(kind_r, step_r, addr_r, word_r);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb
    begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        addr_nxt = addr_r;
        word_nxt = word_r;
        step_nxt = step_r;
        nop_nxt = nop_r;
        done_nxt = 1'b0;
        fault_nxt = fault_r;
        case (st_r)
            fsp_pkg::FSP_H_IDLE:
            begin
                if (cmd_valid_i)
                begin
                    kind_nxt = cmd_kind_i;
                    addr_nxt = cmd_addr_i;
                    word_nxt = cmd_word_i;
                    step_nxt = 3'h0;
                    st_nxt = fsp_pkg::FSP_H_ISSUE;
                end
            end
            fsp_pkg::FSP_H_ISSUE:
            begin
                // a request counts only in a cycle without stall
                if (!bus.stall)
                begin
                    step_nxt = step_r + 3'h1;
                    if (req.start)
                    begin
                        nop_nxt = 2'(fsp_pkg::HOST_NOP_CYCLES - 1);
                        st_nxt = fsp_pkg::FSP_H_NOP;
                    end
                    else if (req.last)
                    begin
                        done_nxt = 1'b1;
                        st_nxt = fsp_pkg::FSP_H_IDLE;
                    end
                end
            end
            fsp_pkg::FSP_H_NOP:
            begin
                if (nop_r == 2'h0)
                    st_nxt = fsp_pkg::FSP_H_WAIT;
                else
                    nop_nxt = nop_r - 2'h1;
            end
            fsp_pkg::FSP_H_WAIT:
            begin
                if (!bus.stall)
                    st_nxt = fsp_pkg::FSP_H_READ;
            end
            fsp_pkg::FSP_H_READ: st_nxt = fsp_pkg::FSP_H_CAPT;
            fsp_pkg::FSP_H_CAPT:
            begin
                fault_nxt = bus.sfr_rdata[fsp_pkg::CTL_FAULT_BIT];
                done_nxt = 1'b1;
                st_nxt = fsp_pkg::FSP_H_IDLE;
            end
            default: st_nxt = fsp_pkg::FSP_H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            st_r <= fsp_pkg::FSP_H_IDLE;
            kind_r <= 2'h0;
            addr_r <= 24'h000000;
            word_r <= 24'h000000;
            step_r <= 3'h0;
            nop_r <= 2'h0;
            done_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            addr_r <= addr_nxt;
            word_r <= word_nxt;
            step_r <= step_nxt;
            nop_r <= nop_nxt;
            done_r <= done_nxt;
            fault_r <= fault_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus drive; held steady while stalled
    assign bus.tbl_wr = (st_r == fsp_pkg::FSP_H_ISSUE) && req.tbl;
    assign bus.tbl_hi = req.hi;
    assign bus.tbl_ea = addr_r;
    assign bus.tbl_wdata = req.data;
    assign bus.sfr_wr = (st_r == fsp_pkg::FSP_H_ISSUE) && !req.tbl;
    assign bus.sfr_rd = (st_r == fsp_pkg::FSP_H_READ);
    assign bus.sfr_addr = (st_r == fsp_pkg::FSP_H_READ) ? fsp_pkg::ADDR_CTRL : req.addr;
    assign bus.sfr_wdata = req.data;
    assign cmd_ready_o = (st_r == fsp_pkg::FSP_H_IDLE);
    assign done_o = done_r;
    assign fault_o = fault_r;
endmodule

// [hw/fsp_if.sv]
/*
 * Core-to-controller connection: special register port, table write
 * port and the stall line back to the core.
 * Assumes both ends share ref_clk_i; no clocking block is used.
 */
`timescale 1ns/1ps
interface fsp_if;
    logic sfr_wr;
    logic sfr_rd;
    logic [15:0] sfr_addr;
    logic [15:0] sfr_wdata;
    logic [15:0] sfr_rdata;
    logic tbl_wr;
    logic tbl_hi;
    logic [23:0] tbl_ea;
    logic [15:0] tbl_wdata;
    logic stall;

    modport dev (
        input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, tbl_wr, tbl_hi, tbl_ea, tbl_wdata,
        output sfr_rdata, stall
    );
    modport core (
        output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, tbl_wr, tbl_hi, tbl_ea, tbl_wdata,
        input sfr_rdata, stall
    );
endinterface

// [hw/fsp_pkg.sv]
/*
 * Shared constants and types for the row self-programming controller
 * and the core-side sequencer that drives it.
 * Assumes one 100 MHz core clock and a synchronous active-high reset.
 */
// Notes on behaviour
// - rows hold 32 instruction words, 96 bytes
// - 128 rows per panel, own latch set
// - one erase clears a row, program writes 32
// - latches hold 32 words, filled before program
// - host loads ascending from aligned row start
// - 32 low and 32 high table writes
// - latch table write takes two cycles
// - only explicit start alters flash contents
// - low address captures table EA 15:0
// - high address captures table EA 23:16
// - software may write address registers directly
// - write-only key, 0x55 then 0xAA
// - control selects operation, holds start bit
// - operation lasts 2 ms, core stalled
// - start bit 15, hardware clears at end
// - erase: control 0x4041, address, keys, start
// - program: control setup, keys, start
// - high byte write uses low byte only
// - host idles two cycles after start
// - write allow bit gates start, clear after reset
// - warm reset mid-operation sets fault, keeps address
package fsp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [15:0] ADDR_CTRL = 16'h0760;
    localparam logic [15:0] ADDR_ADR_LO = 16'h0762;
    localparam logic [15:0] ADDR_ADR_HI = 16'h0764;
    localparam logic [15:0] ADDR_KEY = 16'h0766;

    localparam int CTL_START_BIT = 15;
    localparam int CTL_WALLOW_BIT = 14;
    localparam int CTL_FAULT_BIT = 13;
    localparam int CTL_TWRI_BIT = 8;
    localparam int OPSEL_W = 7;

    localparam logic [6:0] OP_ROW_ERASE = 7'h41;
    localparam logic [6:0] OP_ROW_PROG = 7'h01;
    localparam logic [15:0] CTL_ERASE_SETUP = 16'h4041;
    localparam logic [15:0] CTL_PROG_SETUP = 16'h4001;
    localparam logic [15:0] CTL_START_MASK = 16'h8000;
    localparam logic [15:0] ADR_RESET = 16'h0000;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    ////////////////////////////////////////////////////////////////////////////
    // memory geometry; the table address steps by two per instruction
    localparam int ROW_WORDS = 32;
    localparam int ROW_BYTES = 96;
    localparam int PANEL_ROWS = 128;
    localparam int IDX_W = 5;
    localparam int EA_IDX_LSB = 1;
    localparam int EA_ROW_LSB = 6;
    localparam int EA_PANEL_LSB = 13;
    localparam int WORD_W = 24;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int OP_TIME_MS = 2;
    localparam int OP_CYCLES = OP_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TBL_WR_CYCLES = 2;
    localparam int HOST_NOP_CYCLES = 2;

    typedef enum logic [1:0] {
        FSP_KEY_IDLE = 2'b00,
        FSP_KEY_GOT1 = 2'b01,
        FSP_KEY_OPEN = 2'b10
    } fsp_key_e;

    typedef enum logic [0:0] {
        FSP_OP_IDLE = 1'b0,
        FSP_OP_RUN = 1'b1
    } fsp_op_e;

    typedef enum logic [1:0] {
        FSP_CMD_LOAD = 2'b00,
        FSP_CMD_ERASE = 2'b01,
        FSP_CMD_PROG = 2'b10
    } fsp_cmd_e;

    typedef enum logic [2:0] {
        FSP_H_IDLE = 3'b000,
        FSP_H_ISSUE = 3'b001,
        FSP_H_NOP = 3'b010,
        FSP_H_WAIT = 3'b011,
        FSP_H_READ = 3'b100,
        FSP_H_CAPT = 3'b101
    } fsp_hst_e;

    // one core bus request of a host sequence
    typedef struct packed {
        logic tbl;
        logic hi;
        logic [15:0] addr;
        logic [15:0] data;
        logic last;
        logic start;
    } fsp_req_s;

endpackage
